// ### shared/ckc_pkg.sv
// constants and carrier types for the clock controller with ratio and loop logic
// assumes the oscillator is the system clock and registers sit on the byte-wide sfr port
// Operation
// - separate cpu, peripheral and usb clock outputs
// - oscillator period counter feeds all peripheral tick derivation
// - power-reduction modes gate each clock output
// - crystal or external 48 mhz oscillator source
// - inverter off unless loop output feeds usb
// - loop makes usb clock from peripheral reference
// - detector compares n-ref with r-feedback, up/down
// - loop runs only while loop_enable set
// - hardware sets loop_lock_flag on lock
// - ratio bits honoured only with double_speed_mode
// - ratio bit clear six, set twelve periods
// - spi ratio bits 7-1 read zero
// - both ratio registers reset to zero
package ckc_pkg;
    localparam logic [7:0] RATIO_ADDR     = 8'h8f;
    localparam logic [7:0] SPI_RATIO_ADDR = 8'haf;
    localparam logic [7:0] LOOP_CTRL_ADDR = 8'ha3;
    localparam logic [7:0] LOOP_DIV_ADDR  = 8'ha4;
    localparam logic [7:0] RATIO_RST      = 8'h00;
    localparam logic [7:0] SPI_RATIO_RST  = 8'h00;
    localparam logic [7:0] LOOP_CTRL_RST  = 8'h00;
    localparam logic [7:0] LOOP_DIV_RST   = 8'h00;
    localparam int DSM_BIT      = 0;
    localparam int SPI_BIT      = 0;
    localparam int LOCK_BIT     = 0;
    localparam int LEN_BIT      = 1;
    localparam int EXT48_BIT    = 2;
    localparam int R_LSB        = 4;
    localparam int N_LSB        = 0;
    localparam logic [3:0] STD_LAST  = 4'h0b;
    localparam logic [3:0] FAST_MID  = 4'h05;
    localparam logic [3:0] LOCK_HITS = 4'h8;
    localparam logic [7:0] DCO_INIT  = 8'h10;
    localparam logic [7:0] DCO_MAX   = 8'hff;

    typedef struct packed {
        logic two_wire;
        logic watchdog;
        logic counter_array;
        logic serial_port;
        logic timer2;
        logic timer1;
        logic timer0;
        logic spi;
    } ckc_ticks_t;

    typedef enum logic [2:0] {
        LOOP_OFF     = 3'b001,
        LOOP_ACQUIRE = 3'b010,
        LOOP_LOCKED  = 3'b100
    } ckc_loop_t;

    typedef struct packed {
        logic [7:0] ratio_reg;
        logic [7:0] spi_reg;
        logic [7:0] ctrl_reg;
        logic [7:0] div_reg;
        logic [7:0] rdata;
        logic [3:0] osc_cnt;
        logic       phase;
        ckc_ticks_t ticks;
        logic       cpu_clk;
        logic       cpu_cycle;
        logic       periph_clk;
        logic       usb_clk;
        logic [3:0] ref_cnt;
        logic [3:0] fb_cnt;
        logic [1:0] fb_edges;
        logic [7:0] dco_cnt;
        logic [7:0] dco_period;
        logic [3:0] hits;
        logic       up;
        logic       down;
        ckc_loop_t  loop;
    } ckc_state_t;
endpackage

// ### core/ckc_top.sv
// clock controller: ratio registers, clock strobes, digital loop model
// assumes i_sys_clk is the oscillator and sfr accesses are single-cycle strobes
`timescale 1ns/1ps
module ckc_top (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic              i_sfr_wr,
    input  wire logic              i_sfr_rd,
    input  wire logic [7:0]        i_sfr_wdata,
    output logic      [7:0]        o_sfr_rdata,
    input  wire logic              i_idle,
    input  wire logic              i_power_down,
    output logic                   o_cpu_clk,
    output logic                   o_cpu_cycle,
    output logic                   o_periph_clk,
    output ckc_pkg::ckc_ticks_t    o_periph_ticks,
    output logic                   o_usb_clk,
    output logic                   o_osc_inverter_en,
    output logic                   o_loop_up,
    output logic                   o_loop_down,
    output logic                   o_loop_lock
);
    ckc_pkg::ckc_state_t s_reg;
    ckc_pkg::ckc_state_t s_next;

    logic       dsm;
    logic       len;
    logic       ext48;
    logic       tick6;
    logic       tick12;
    logic       base;
    logic       ref_edge;
    logic       fb_edge;
    logic       dco_tick;
    logic [3:0] r_last;
    logic [3:0] n_last;

    // six- or twelve-period strobe for one ratio bit
    function automatic logic ratio_tick(input logic x2, input logic bit_set,
                                        input logic t6, input logic t12);
        ratio_tick = (x2 && !bit_set) ? t6 : t12;
    endfunction

    assign dsm      = s_reg.ratio_reg[ckc_pkg::DSM_BIT];
    assign len      = s_reg.ctrl_reg[ckc_pkg::LEN_BIT];
    assign ext48    = s_reg.ctrl_reg[ckc_pkg::EXT48_BIT];
    assign r_last   = s_reg.div_reg[ckc_pkg::R_LSB +: 4];
    assign n_last   = s_reg.div_reg[ckc_pkg::N_LSB +: 4];
    assign tick12   = (s_reg.osc_cnt == ckc_pkg::STD_LAST);
    assign tick6    = tick12 || (s_reg.osc_cnt == ckc_pkg::FAST_MID);
    // standard speed halves the oscillator, double speed passes every period
    assign base     = dsm || s_reg.phase;
    assign ref_edge = base && (s_reg.ref_cnt == n_last);
    assign dco_tick = (s_reg.dco_cnt >= s_reg.dco_period);
    assign fb_edge  = dco_tick && (s_reg.fb_cnt == r_last);

    always_comb begin
        s_next = s_reg;
        // register writes
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                ckc_pkg::RATIO_ADDR: begin
                    s_next.ratio_reg = i_sfr_wdata;
                end
                ckc_pkg::SPI_RATIO_ADDR: begin
                    s_next.spi_reg = {7'h00, i_sfr_wdata[ckc_pkg::SPI_BIT]};
                end
                ckc_pkg::LOOP_CTRL_ADDR: begin
                    // lock bit stays hardware-owned, reserved bits stay zero
                    s_next.ctrl_reg[ckc_pkg::LEN_BIT]   = i_sfr_wdata[ckc_pkg::LEN_BIT];
                    s_next.ctrl_reg[ckc_pkg::EXT48_BIT] = i_sfr_wdata[ckc_pkg::EXT48_BIT];
                end
                ckc_pkg::LOOP_DIV_ADDR: begin
                    s_next.div_reg = i_sfr_wdata;
                end
                default: begin
                end
            endcase
        end
        // registered read data, unmapped reads give zero
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                ckc_pkg::RATIO_ADDR:     s_next.rdata = s_reg.ratio_reg;
                ckc_pkg::SPI_RATIO_ADDR: s_next.rdata = s_reg.spi_reg;
                ckc_pkg::LOOP_CTRL_ADDR: s_next.rdata = s_reg.ctrl_reg;
                ckc_pkg::LOOP_DIV_ADDR:  s_next.rdata = s_reg.div_reg;
                default:                 s_next.rdata = 8'h00;
            endcase
        end
        // oscillator period counter shared by every strobe
        s_next.osc_cnt = tick12 ? 4'h0 : s_reg.osc_cnt + 4'h1;
        s_next.phase   = !s_reg.phase;
        // gating by power-reduction mode
        s_next.cpu_clk    = base && !i_idle && !i_power_down;
        s_next.periph_clk = base && !i_power_down;
        s_next.cpu_cycle  = (dsm ? tick6 : tick12) && !i_idle && !i_power_down;
        s_next.ticks.two_wire      = ratio_tick(dsm, s_reg.ratio_reg[7], tick6, tick12);
        s_next.ticks.watchdog      = ratio_tick(dsm, s_reg.ratio_reg[6], tick6, tick12);
        s_next.ticks.counter_array = ratio_tick(dsm, s_reg.ratio_reg[5], tick6, tick12);
        s_next.ticks.serial_port   = ratio_tick(dsm, s_reg.ratio_reg[4], tick6, tick12);
        s_next.ticks.timer2        = ratio_tick(dsm, s_reg.ratio_reg[3], tick6, tick12);
        s_next.ticks.timer1        = ratio_tick(dsm, s_reg.ratio_reg[2], tick6, tick12);
        s_next.ticks.timer0        = ratio_tick(dsm, s_reg.ratio_reg[1], tick6, tick12);
        s_next.ticks.spi           = ratio_tick(dsm, s_reg.spi_reg[ckc_pkg::SPI_BIT],
                                                tick6, tick12);
        if (i_power_down) begin
            s_next.ticks = '0;
        end
        // usb clock: external 48 mhz bypass or loop output
        s_next.usb_clk = !i_power_down && (ext48 || (len && dco_tick));
        s_next.up   = 1'b0;
        s_next.down = 1'b0;
        case (s_reg.loop)
            ckc_pkg::LOOP_OFF: begin
                s_next.dco_cnt    = 8'h00;
                s_next.dco_period = ckc_pkg::DCO_INIT;
                s_next.ref_cnt    = 4'h0;
                s_next.fb_cnt     = 4'h0;
                s_next.fb_edges   = 2'b00;
                s_next.hits       = 4'h0;
                if (len && !ext48) begin
                    s_next.loop = ckc_pkg::LOOP_ACQUIRE;
                end
            end
            ckc_pkg::LOOP_ACQUIRE, ckc_pkg::LOOP_LOCKED: begin
                s_next.dco_cnt = dco_tick ? 8'h00 : s_reg.dco_cnt + 8'h01;
                if (dco_tick) begin
                    s_next.fb_cnt = fb_edge ? 4'h0 : s_reg.fb_cnt + 4'h1;
                end
                if (base) begin
                    s_next.ref_cnt = ref_edge ? 4'h0 : s_reg.ref_cnt + 4'h1;
                end
                if (fb_edge && s_reg.fb_edges != 2'b11) begin
                    s_next.fb_edges = s_reg.fb_edges + 2'b01;
                end
                if (ref_edge) begin
                    // feedback count between two reference edges decides the pulse
                    s_next.fb_edges = {1'b0, fb_edge};
                    if (s_reg.fb_edges == 2'b00) begin
                        s_next.up   = 1'b1;
                        s_next.hits = 4'h0;
                        if (s_reg.dco_period != 8'h00) begin
                            s_next.dco_period = s_reg.dco_period - 8'h01;
                        end
                    end else if (s_reg.fb_edges != 2'b01) begin
                        s_next.down = 1'b1;
                        s_next.hits = 4'h0;
                        if (s_reg.dco_period != ckc_pkg::DCO_MAX) begin
                            s_next.dco_period = s_reg.dco_period + 8'h01;
                        end
                    end else if (s_reg.hits != ckc_pkg::LOCK_HITS) begin
                        s_next.hits = s_reg.hits + 4'h1;
                    end
                end
                if (s_next.hits == ckc_pkg::LOCK_HITS) begin
                    s_next.loop = ckc_pkg::LOOP_LOCKED;
                end else begin
                    s_next.loop = ckc_pkg::LOOP_ACQUIRE;
                end
                if (!len || ext48) begin
                    s_next.loop = ckc_pkg::LOOP_OFF;
                end
            end
            default: begin
                s_next.loop = ckc_pkg::LOOP_OFF;
            end
        endcase
        // lock flag mirrors the detector, software cannot set it
        s_next.ctrl_reg[ckc_pkg::LOCK_BIT] = (s_next.loop == ckc_pkg::LOOP_LOCKED);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_reg            <= '0;
            s_reg.ratio_reg  <= ckc_pkg::RATIO_RST;
            s_reg.spi_reg    <= ckc_pkg::SPI_RATIO_RST;
            s_reg.ctrl_reg   <= ckc_pkg::LOOP_CTRL_RST;
            s_reg.div_reg    <= ckc_pkg::LOOP_DIV_RST;
            s_reg.dco_period <= ckc_pkg::DCO_INIT;
            s_reg.loop       <= ckc_pkg::LOOP_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_sfr_rdata       = s_reg.rdata;
    assign o_cpu_clk         = s_reg.cpu_clk;
    assign o_cpu_cycle       = s_reg.cpu_cycle;
    assign o_periph_clk      = s_reg.periph_clk;
    assign o_periph_ticks    = s_reg.ticks;
    assign o_usb_clk         = s_reg.usb_clk;
    // inverter only runs when the loop drives usb; bypass leaves it idle
    assign o_osc_inverter_en = len && !ext48;
    assign o_loop_up         = s_reg.up;
    assign o_loop_down       = s_reg.down;
    assign o_loop_lock       = s_reg.ctrl_reg[ckc_pkg::LOCK_BIT];

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    a_spi_reserved_zero: assert property (
        (i_sfr_rd && i_sfr_addr == ckc_pkg::SPI_RATIO_ADDR) |=> o_sfr_rdata[7:1] == 7'h00)
        else $error("spi ratio reserved bits not zero");
    a_ratio_ignored_std: assert property (
        (!dsm && !i_power_down) |=> o_periph_ticks == {8{$past(tick12)}})
        else $error("ratio bit honoured in standard speed");
    a_timer0_six_period: assert property (
        (dsm && !s_reg.ratio_reg[1] && o_periph_ticks.timer0 && !i_power_down && !i_sfr_wr)
        ##1 (!i_sfr_wr && !i_power_down)[*5] |=> o_periph_ticks.timer0)
        else $error("timer0 fast tick not six periods");
    a_loop_off_silent: assert property (
        (!len && !ext48)[*2] |-> !o_usb_clk && !o_loop_lock)
        else $error("usb clock without loop enable");
    a_lock_after_hits: assert property (
        $rose(o_loop_lock) |-> $past(s_reg.hits) == ckc_pkg::LOCK_HITS - 4'h1 && len)
        else $error("lock set without enough hits");
    a_inverter_sel: assert property (
        (ext48 || !len) |-> !o_osc_inverter_en)
        else $error("inverter active while loop not selected");
    a_pfd_exclusive: assert property (
        (o_loop_up || o_loop_down) |-> !(o_loop_up && o_loop_down) && !o_loop_lock)
        else $error("detector pulse conflict");
    a_power_down_gate: assert property (
        i_power_down |=> !o_cpu_clk && !o_periph_clk && !o_usb_clk && o_periph_ticks == '0)
        else $error("clock running in power down");
    a_cpu_std_half: assert property (
        // a speed change leaves one doubled pulse, so standard speed must hold a cycle first
        !dsm ##1 (!dsm && !i_idle && !i_power_down && o_cpu_clk && !i_sfr_wr) |=> !o_cpu_clk)
        else $error("cpu clock not halved in standard speed");
    a_reset_zero: assert property (
        $fell(i_rst) |-> s_reg.ratio_reg == 8'h00 && s_reg.spi_reg == 8'h00)
        else $error("ratio registers not cleared by reset");

    c_lock_reached: cover property ($rose(o_loop_lock));
    c_double_speed: cover property (dsm && o_cpu_cycle);
    c_ext_bypass:   cover property (ext48 && o_usb_clk);
endmodule

// ### tb/ckc_consumer.sv
// consumer model: cpu core and peripherals timing the strobes handed to them
// assumes every strobe is a one-cycle pulse on the rising oscillator edge
`timescale 1ns/1ps
module ckc_consumer (
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst,
    input  wire logic                i_cpu_cycle,
    input  wire ckc_pkg::ckc_ticks_t i_ticks,
    output logic [8:0][7:0]          o_gap
);
    logic [8:0]      hit;
    logic [8:0][7:0] cnt;
    // each timer, counter, watchdog and sampling tick comes from the oscillator period counter
    assign hit = {i_cpu_cycle, i_ticks};
    // gap is the distance between the two latest pulses; holds its value when strobes stop, the counter saturating at 255
    always_ff @(posedge i_sys_clk) begin
        for (int k = 0; k < 9; k++) begin
            if (i_rst || hit[k]) begin
                cnt[k] <= 8'h01;
            end else if (cnt[k] != 8'hff) begin
                cnt[k] <= cnt[k] + 8'h01;
            end
            if (i_rst) begin
                o_gap[k] <= 8'h00;
            end else if (hit[k]) begin
                o_gap[k] <= cnt[k];
            end
        end
    end
endmodule

// ### tb/test_clock_controller_pll_ratio.sv
// self-checking bench for the clock controller: registers, strobes, loop
// assumes the consumer model times every strobe the design hands out
`timescale 1ns/1ps
module test_clock_controller_pll_ratio;
    logic                clk;
    logic                rst;
    logic [7:0]          addr;
    logic                wr;
    logic                rd;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    logic                idle;
    logic                pd;
    logic                cpu_clk;
    logic                cpu_cyc;
    logic                per_clk;
    ckc_pkg::ckc_ticks_t ticks;
    logic                usb;
    logic                inv_en;
    logic                up;
    logic                dn;
    logic                lock;
    logic                adj_seen;
    logic [8:0][7:0]     gap;
    logic [7:0]          v;
    logic [7:0]          s;
    logic [7:0]          r;
    logic [7:0]          corner [3];
    int                  n_errors;
    int                  total_checks;
    int                  cyc = 0;
    int                  seed;
    int                  c_cpu, c_cyc, c_tick, c_per, c_usb;

    ckc_top i_dut (.i_sys_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_idle(idle),
        .i_power_down(pd), .o_cpu_clk(cpu_clk), .o_cpu_cycle(cpu_cyc),
        .o_periph_clk(per_clk), .o_periph_ticks(ticks), .o_usb_clk(usb),
        .o_osc_inverter_en(inv_en), .o_loop_up(up), .o_loop_down(dn), .o_loop_lock(lock));
    ckc_consumer i_cons (.i_sys_clk(clk), .i_rst(rst), .i_cpu_cycle(cpu_cyc),
        .i_ticks(ticks), .o_gap(gap));

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (rst) begin
            adj_seen <= 1'b0;
        end else if (up || dn) begin
            adj_seen <= 1'b1;
        end
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    // six periods only when double speed is on and the ratio bit is clear
    function automatic logic [7:0] exp_gap(input logic fast, input logic slow_bit);
        return (fast && !slow_bit) ? 8'h06 : 8'h0c;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %0t mismatch got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // data is registered at the taking edge, so look one edge later
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic win(input int n);
        {c_cpu, c_cyc, c_tick, c_per, c_usb} = '0;
        repeat (n) begin
            @(posedge clk);
            #1;
            c_cpu  += int'(cpu_clk === 1'b1);
            c_cyc  += int'(cpu_cyc === 1'b1);
            c_tick += int'(ticks !== 8'h00);
            c_per  += int'(per_clk === 1'b1);
            c_usb  += int'(usb === 1'b1);
        end
    endtask

    task automatic final_report();
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 32'ha864_29b1;
        corner = '{8'hff, 8'hfe, 8'h01};
        {clk, addr, wr, rd, wdata, idle, pd} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ckc_pkg::RATIO_ADDR);
        check(rdata, 8'h00);
        rd_reg(ckc_pkg::SPI_RATIO_ADDR);
        check(rdata, 8'h00);
        rd_reg(ckc_pkg::LOOP_CTRL_ADDR);
        check(rdata, 8'h00);
        wr_reg(8'h90, 8'hff);
        rd_reg(8'h90);
        check(rdata, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = (i < 3) ? corner[i] : 8'($random(seed));
            s = (i == 0) ? 8'hff : 8'($random(seed));
            wr_reg(ckc_pkg::RATIO_ADDR, v);
            wr_reg(ckc_pkg::SPI_RATIO_ADDR, s);
            rd_reg(ckc_pkg::RATIO_ADDR);
            check(rdata, v);
            rd_reg(ckc_pkg::SPI_RATIO_ADDR);
            check(rdata, {7'h00, s[0]});
            win(40);
            check(c_cpu, v[0] ? 40 : 20);
            check(c_per, v[0] ? 40 : 20);
            check(gap[8], v[0] ? 8'h06 : 8'h0c);
            check(gap[0], exp_gap(v[0], s[0]));
            for (int k = 1; k < 8; k++) begin
                check(gap[k], exp_gap(v[0], v[k]));
            end
        end
        @(posedge clk);
        idle <= 1'b1;
        win(30);
        check(c_cyc, 0);
        check(c_cpu, 0);
        check(c_per > 0, 1);
        check(c_tick > 0, 1);
        @(posedge clk);
        pd <= 1'b1;
        win(30);
        check({c_cpu, c_tick, c_per, c_usb} == '0, 1);
        @(posedge clk);
        {idle, pd} <= 2'b00;
        r = 8'($random(seed));
        wr_reg(ckc_pkg::LOOP_DIV_ADDR, r);
        rd_reg(ckc_pkg::LOOP_DIV_ADDR);
        check(rdata, r);
        wr_reg(ckc_pkg::LOOP_DIV_ADDR, 8'h00);
        #1;
        check(inv_en, 1'b0);
        wr_reg(ckc_pkg::LOOP_CTRL_ADDR, 8'h02);
        #1;
        check(inv_en, 1'b1);
        win(40);
        check(c_usb > 0, 1);
        r = 8'h00;
        for (int i = 0; i < 2000 && r[0] !== 1'b1; i++) begin
            rd_reg(ckc_pkg::LOOP_CTRL_ADDR);
            r = rdata;
        end
        check(r, 8'h03);
        check(lock, 1'b1);
        check(adj_seen, 1'b1);
        wr_reg(ckc_pkg::LOOP_CTRL_ADDR, 8'hfe);
        rd_reg(ckc_pkg::LOOP_CTRL_ADDR);
        check(rdata & 8'hf8, 8'h00);
        check(inv_en, 1'b0);
        win(12);
        check(c_usb, 12);
        wr_reg(ckc_pkg::LOOP_CTRL_ADDR, 8'h00);
        win(12);
        check(c_usb, 0);
        check(lock, 1'b0);
        // second reset while the ratio registers still hold random values
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ckc_pkg::RATIO_ADDR);
        check(rdata, 8'h00);
        rd_reg(ckc_pkg::SPI_RATIO_ADDR);
        check(rdata, 8'h00);
        final_report();
    end
endmodule
